/* File: src/pos_consts.svh */
// Purpose: timing counts, register offsets, field positions and reset values
// Assumes: 250 MHz ref_clk, 32-bit register port with byte addresses
// Notes: percent values are in 0.01 % steps, times in 0.1 s steps
`ifndef POS_CONSTS_SVH
`define POS_CONSTS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define POS_CLK_PERIOD_NS 4
`define POS_TICK_NS 100000000
`define POS_TICK_CYCLES (`POS_TICK_NS / `POS_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define POS_REG_CTRL 8'h00
`define POS_REG_GAIN 8'h04
`define POS_REG_LOW_LEVEL 8'h08
`define POS_REG_LOW_TIME 8'h0c
`define POS_REG_HIGH_LEVEL 8'h10
`define POS_REG_HIGH_TIME 8'h14
`define POS_REG_SLEEP_LEVEL 8'h18
`define POS_REG_SLEEP_DELAY 8'h1c
`define POS_REG_RAMP_TIME 8'h20
`define POS_REG_TARGET 8'h24
`define POS_REG_FULL_SCALE 8'h28
`define POS_REG_DECIMALS 8'h2c
`define POS_REG_STATUS 8'h30
`define POS_REG_OUT_FREQ 8'h34
`define POS_REG_TARGET_MON 8'h38
`define POS_REG_FB_MON 8'h3c

// ---------------------------------------------------------------
// control and status fields
// ---------------------------------------------------------------
`define POS_CTRL_SIGN 0
`define POS_CTRL_REVERSE 1
`define POS_CTRL_MODE_LO 2
`define POS_CTRL_ACTION_LO 5
`define POS_CTRL_TSEL 8
`define POS_CTRL_UNIT_LO 9
`define POS_CTRL_SOFTSTART 11
`define POS_CTRL_STOP_LO 12
`define POS_STATUS_FAULT_CLR 3

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define POS_GAIN_RST 14'd100
`define POS_GAIN_MAX 14'd2500
`define POS_LOW_LEVEL_RST 14'd0
`define POS_HIGH_LEVEL_RST 14'd10000
`define POS_LEVEL_MAX 14'd10000
`define POS_LOW_TIME_RST 8'd10
`define POS_HIGH_TIME_RST 8'd10
`define POS_SLEEP_DELAY_RST 8'd0
`define POS_RAMP_TIME_MAX 16'd60000
`define POS_TARGET_RST 14'd0
`define POS_FULL_SCALE_RST 16'd0
`define POS_FULL_SCALE_MAX 16'd60000
`define POS_DECIMALS_RST 2'd2
`define POS_UNIT_RST 2'd1
`define POS_MODE_MAX 3'd4
`define POS_ACTION_MAX 3'd5
`define POS_UNIT_USER 2'd3
`define POS_PCT_FULL 32'd10000

`endif

/* File: src/pos_pkg.sv */
// Purpose: shared types of the pid output supervision block
// Assumes: used by pos_pid_supervision only
// Notes: sleep machine codes are one-hot
package pos_pkg;

  // sleep machine states
  typedef enum logic [1:0] {
    POS_AWAKE = 2'b01,
    POS_ASLEEP = 2'b10
  } pos_sleep_e;

  // reaction to an out-of-range feedback
  typedef enum logic [1:0] {
    POS_ACT_OUTPUT = 2'd0,
    POS_ACT_ALARM = 2'd1,
    POS_ACT_FAULT = 2'd2
  } pos_act_e;

endpackage

/* File: src/pos_pid_supervision.sv */
// Purpose: post-processing and supervision of the process pid output
// Assumes: pid_in, freq_cmd, target_ext and feedback are synchronous to ref_clk
// Notes: percent in 0.01 % steps of max frequency, times in 0.1 s steps
//
// Contract
// [R1] sign select 1 inverts pid output
// [R2] sign select 0 passes pid output unchanged
// [R3] pid output times gain 0.00..25.00
// [R4] modes 3,4 add frequency command
// [R5] modes 3,4 ignore reverse, no limit
// [R6] reverse off: negative clamps, drive stops
// [R7] reverse on: negative output runs reverse
// [R8] feedback low after level/time hold
// [R9] feedback high after level/time hold
// [R10] action 0: indicators only, self clearing
// [R11] action 1: alarm plus indicator, self clearing
// [R12] action 2: fault output, motor stops
// [R13] actions 3..5 also work pid disabled
// [R14] sleep and wake after level/delay hold
// [R15] sleep stops with chosen stop method
// [R16] target ramp, bypassed by soft start
// [R17] target select picks internal target
// [R18] internal target 0..100.00 percent
// [R19] display scaled by unit code
// [R20] user scale edits need unit 3
// [R21] user full scale and decimal places
// [R22] duration timers restart when condition drops
//
// The register addresses and the plain strobed port were chosen for this implementation.
`include "pos_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pos_pid_supervision #(
  parameter int TICK_CYCLES = `POS_TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // pid core and command path
  input wire logic signed [15:0] pid_in,
  input wire logic [15:0] freq_cmd,
  input wire logic [15:0] target_ext,
  input wire logic [15:0] feedback,
  input wire logic [15:0] max_freq_hz,
  input wire logic [15:0] max_rpm,
  // drive command
  output logic [15:0] out_freq,
  output logic out_reverse,
  output logic stop_req,
  output logic [1:0] stop_method,
  output logic sleep_active,
  // indicator outputs
  output logic fb_low_ind,
  output logic fb_high_ind,
  output logic alarm_out,
  output logic fault_out,
  // target and monitors
  output logic [15:0] target_ramped,
  output logic [15:0] target_display,
  output logic [15:0] feedback_display
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 33554431) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic sign_sel, rev_sel, tsel, soft_start;
  logic [2:0] mode, action;
  logic [1:0] unit_code;
  logic [13:0] gain, low_level, high_level, target_val;
  logic [7:0] low_time, high_time, sleep_delay;
  logic [15:0] sleep_level, ramp_time, full_scale;
  logic [1:0] decimals;
  logic fault_clr;
  logic wr_user;

  assign wr_user = reg_wr && (unit_code == `POS_UNIT_USER);

  // software writes; out-of-range values of checked fields are ignored, not clipped; time and sleep level writes keep only their low bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sign_sel <= 1'b0;
      rev_sel <= 1'b0;
      mode <= 3'd0;
      action <= 3'd0;
      tsel <= 1'b0;
      unit_code <= `POS_UNIT_RST;
      soft_start <= 1'b0;
      stop_method <= 2'd0;
      gain <= `POS_GAIN_RST;
      low_level <= `POS_LOW_LEVEL_RST;
      high_level <= `POS_HIGH_LEVEL_RST;
      low_time <= `POS_LOW_TIME_RST;
      high_time <= `POS_HIGH_TIME_RST;
      sleep_level <= 16'd0;
      sleep_delay <= `POS_SLEEP_DELAY_RST;
      ramp_time <= 16'd0;
      target_val <= `POS_TARGET_RST;
      full_scale <= `POS_FULL_SCALE_RST;
      decimals <= `POS_DECIMALS_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `POS_REG_CTRL: begin
          sign_sel <= reg_wdata[`POS_CTRL_SIGN];
          rev_sel <= reg_wdata[`POS_CTRL_REVERSE];
          if (reg_wdata[`POS_CTRL_MODE_LO +: 3] <= `POS_MODE_MAX) begin
            mode <= reg_wdata[`POS_CTRL_MODE_LO +: 3];
          end
          if (reg_wdata[`POS_CTRL_ACTION_LO +: 3] <= `POS_ACTION_MAX) begin // [R13]
            action <= reg_wdata[`POS_CTRL_ACTION_LO +: 3];
          end
          tsel <= reg_wdata[`POS_CTRL_TSEL];
          unit_code <= reg_wdata[`POS_CTRL_UNIT_LO +: 2];
          soft_start <= reg_wdata[`POS_CTRL_SOFTSTART];
          stop_method <= reg_wdata[`POS_CTRL_STOP_LO +: 2];
        end
        `POS_REG_GAIN: begin
          if (reg_wdata[31:0] <= 32'(`POS_GAIN_MAX)) begin // [R3]
            gain <= reg_wdata[13:0];
          end
        end
        `POS_REG_LOW_LEVEL: begin
          if (reg_wdata <= 32'(`POS_LEVEL_MAX)) begin
            low_level <= reg_wdata[13:0];
          end
        end
        `POS_REG_LOW_TIME: low_time <= reg_wdata[7:0];
        `POS_REG_HIGH_LEVEL: begin
          if (reg_wdata <= 32'(`POS_LEVEL_MAX)) begin
            high_level <= reg_wdata[13:0];
          end
        end
        `POS_REG_HIGH_TIME: high_time <= reg_wdata[7:0];
        `POS_REG_SLEEP_LEVEL: sleep_level <= reg_wdata[15:0];
        `POS_REG_SLEEP_DELAY: sleep_delay <= reg_wdata[7:0];
        `POS_REG_RAMP_TIME: begin
          if (reg_wdata <= 32'(`POS_RAMP_TIME_MAX)) begin
            ramp_time <= reg_wdata[15:0];
          end
        end
        `POS_REG_TARGET: begin
          if (reg_wdata <= 32'(`POS_LEVEL_MAX)) begin // [R18]
            target_val <= reg_wdata[13:0];
          end
        end
        `POS_REG_FULL_SCALE: begin
          if (wr_user && reg_wdata != 32'd0 && reg_wdata <= 32'(`POS_FULL_SCALE_MAX)) begin // [R20] [R21]
            full_scale <= reg_wdata[15:0];
          end
        end
        `POS_REG_DECIMALS: begin
          if (wr_user && reg_wdata[31:2] == 30'd0) begin // [R20] [R21]
            decimals <= reg_wdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign fault_clr = reg_wr && (reg_addr == `POS_REG_STATUS) && reg_wdata[`POS_STATUS_FAULT_CLR];

  // ---------------------------------------------------------------
  // 0.1 s time base
  // ---------------------------------------------------------------
  logic [24:0] tick_cnt;
  logic tick;

  // one enable pulse per 0.1 s drives every timer and the ramp
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_cnt <= 25'd0;
      tick <= 1'b0;
    end else if (tick_cnt == 25'(TICK_CYCLES - 1)) begin
      tick_cnt <= 25'd0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 25'd1;
      tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output path: sign, gain, mode and negative handling
  // ---------------------------------------------------------------
  logic signed [16:0] pid_s;
  logic signed [31:0] pid_prod, pid_div;
  logic signed [17:0] pid_out;
  logic signed [18:0] sum_w;
  logic [15:0] next_freq;
  logic next_rev, neg_stop;

  assign pid_s = sign_sel ? -$signed({pid_in[15], pid_in}) : $signed({pid_in[15], pid_in}); // [R1] [R2]
  assign pid_prod = pid_s * $signed({1'b0, gain}); // [R3]
  assign pid_div = pid_prod / 32'sd100;
  assign sum_w = $signed({3'b000, freq_cmd}) + $signed({pid_out[17], pid_out}); // [R4]

  // the product is saturated to the 16-bit magnitude range before use
  always_comb begin
    if (pid_div > 32'sd65535) begin
      pid_out = 18'sd65535;
    end else if (pid_div < -32'sd65535) begin
      pid_out = -18'sd65535;
    end else begin
      pid_out = pid_div[17:0];
    end
  end

  // mode 0 passes the command; modes 3,4 never reverse or limit pid
  always_comb begin
    next_rev = 1'b0;
    neg_stop = 1'b0;
    if (mode == 3'd0) begin
      next_freq = freq_cmd;
    end else if (mode >= 3'd3) begin // [R5]
      if (sum_w < 19'sd0) begin
        next_freq = 16'd0;
      end else if (sum_w > 19'sd65535) begin
        next_freq = 16'hffff;
      end else begin
        next_freq = sum_w[15:0]; // [R4]
      end
    end else if (pid_out < 18'sd0) begin
      if (rev_sel) begin
        next_freq = 16'(-pid_out); // [R7]
        next_rev = 1'b1;
      end else begin
        next_freq = 16'd0; // [R6]
        neg_stop = 1'b1;
      end
    end else begin
      next_freq = pid_out[15:0];
    end
  end

  // ---------------------------------------------------------------
  // duration timers: feedback low, feedback high, sleep
  // ---------------------------------------------------------------
  pos_pkg::pos_sleep_e sleep_st;
  logic det_en;
  logic [2:0] t_cond, t_done;
  logic [7:0] t_limit [3];
  logic [8:0] t_cnt [3];

  assign det_en = (mode != 3'd0) || (action >= 3'd3); // [R13]
  assign t_cond[0] = det_en && (feedback < {2'b00, low_level}); // [R8]
  assign t_cond[1] = det_en && (feedback > {2'b00, high_level}); // [R9]
  assign t_cond[2] = (sleep_st == pos_pkg::POS_AWAKE) ? (next_freq < sleep_level) : (next_freq > sleep_level); // [R14]
  assign t_limit[0] = low_time;
  assign t_limit[1] = high_time;
  assign t_limit[2] = sleep_delay;

  // each timer counts ticks while its level holds, done once past the limit
  for (genvar i = 0; i < 3; i++) begin : g_timer
    always_ff @(posedge ref_clk) begin
      if (reset || !t_cond[i] || (i == 2 && t_done[i])) begin
        t_cnt[i] <= 9'd0; // [R22]
      end else if (tick && t_cnt[i] <= {1'b0, t_limit[i]}) begin
        t_cnt[i] <= t_cnt[i] + 9'd1;
      end
    end
    assign t_done[i] = t_cond[i] && (t_cnt[i] > {1'b0, t_limit[i]});
  end

  // ---------------------------------------------------------------
  // sleep machine
  // ---------------------------------------------------------------
  // the same delay serves entry and exit; the timer restarts on each flip
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sleep_st <= pos_pkg::POS_AWAKE;
    end else begin
      unique case (sleep_st)
        pos_pkg::POS_AWAKE: if (t_done[2]) sleep_st <= pos_pkg::POS_ASLEEP; // [R14]
        pos_pkg::POS_ASLEEP: if (t_done[2]) sleep_st <= pos_pkg::POS_AWAKE; // [R14]
      endcase
    end
  end

  // ---------------------------------------------------------------
  // detection actions and indicators
  // ---------------------------------------------------------------
  pos_pkg::pos_act_e act_base;
  logic fault_hit;

  assign act_base = pos_pkg::pos_act_e'((action >= 3'd3) ? 2'(action - 3'd3) : action[1:0]); // [R13]
  assign fault_hit = (act_base == pos_pkg::POS_ACT_FAULT) && (t_done[0] || t_done[1]);

  // indicators follow the timers except under the fault action and drop when feedback returns to range
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fb_low_ind <= 1'b0;
      fb_high_ind <= 1'b0;
      alarm_out <= 1'b0;
    end else begin
      fb_low_ind <= t_done[0] && (act_base != pos_pkg::POS_ACT_FAULT); // [R10]
      fb_high_ind <= t_done[1] && (act_base != pos_pkg::POS_ACT_FAULT); // [R10]
      alarm_out <= (act_base == pos_pkg::POS_ACT_ALARM) && (t_done[0] || t_done[1]); // [R11]
    end
  end

  // a fault latches; a new hit wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_out <= 1'b0;
    end else if (fault_hit) begin
      fault_out <= 1'b1; // [R12]
    end else if (fault_clr) begin
      fault_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // drive command outputs
  // ---------------------------------------------------------------
  logic stop_any;

  assign stop_any = fault_out || neg_stop || (sleep_st == pos_pkg::POS_ASLEEP); // [R6] [R12] [R15]

  // stop_method is held in the control register and reused for sleep
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_freq <= 16'd0;
      out_reverse <= 1'b0;
      stop_req <= 1'b0;
      sleep_active <= 1'b0;
    end else begin
      out_freq <= stop_any ? 16'd0 : next_freq;
      out_reverse <= next_rev && !stop_any; // [R7]
      stop_req <= stop_any; // [R15]
      sleep_active <= (sleep_st == pos_pkg::POS_ASLEEP);
    end
  end

  // ---------------------------------------------------------------
  // target select and ramp
  // ---------------------------------------------------------------
  logic [15:0] target_src;
  logic [16:0] ramp_acc;
  logic ramp_bypass;

  assign target_src = tsel ? {2'b00, target_val} : target_ext; // [R17]
  assign ramp_bypass = soft_start || (ramp_time == 16'd0); // [R16]

  // full scale per ramp_time ticks, stepped by one count without a divider
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      target_ramped <= 16'd0;
      ramp_acc <= 17'd0;
    end else if (ramp_bypass || target_ramped == target_src) begin
      target_ramped <= target_src; // [R16]
      ramp_acc <= 17'd0;
    end else if (ramp_acc >= {1'b0, ramp_time}) begin
      ramp_acc <= ramp_acc - {1'b0, ramp_time};
      target_ramped <= (target_ramped < target_src) ? target_ramped + 16'd1 : target_ramped - 16'd1;
    end else if (tick) begin
      ramp_acc <= ramp_acc + 17'(`POS_PCT_FULL); // [R16]
    end
  end

  // ---------------------------------------------------------------
  // display scaling
  // ---------------------------------------------------------------
  function automatic logic [15:0] pos_scale(input logic [15:0] val, input logic [1:0] code,
                                            input logic [15:0] hz, input logic [15:0] rpm,
                                            input logic [15:0] user);
    logic [31:0] prod;
    logic [15:0] fs;
    fs = (code == 2'd0) ? hz : (code == 2'd2) ? rpm : user;
    prod = (32'(val) * 32'(fs)) / `POS_PCT_FULL;
    if (code == 2'd1) begin
      pos_scale = val;
    end else if (prod > 32'd65535) begin
      pos_scale = 16'hffff;
    end else begin
      pos_scale = prod[15:0];
    end
  endfunction

  // monitors follow the unit code; decimals only annotate user units
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      target_display <= 16'd0;
      feedback_display <= 16'd0;
    end else begin
      target_display <= pos_scale(target_ramped, unit_code, max_freq_hz, max_rpm, full_scale); // [R19]
      feedback_display <= pos_scale(feedback, unit_code, max_freq_hz, max_rpm, full_scale); // [R19] [R21]
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // unmapped addresses read zero; data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset || !reg_rd) begin
      reg_rdata <= 32'd0;
    end else begin
      unique case (reg_addr)
        `POS_REG_CTRL: reg_rdata <= {18'd0, stop_method, soft_start, unit_code, tsel, action, mode, rev_sel, sign_sel};
        `POS_REG_GAIN: reg_rdata <= {18'd0, gain};
        `POS_REG_LOW_LEVEL: reg_rdata <= {18'd0, low_level};
        `POS_REG_LOW_TIME: reg_rdata <= {24'd0, low_time};
        `POS_REG_HIGH_LEVEL: reg_rdata <= {18'd0, high_level};
        `POS_REG_HIGH_TIME: reg_rdata <= {24'd0, high_time};
        `POS_REG_SLEEP_LEVEL: reg_rdata <= {16'd0, sleep_level};
        `POS_REG_SLEEP_DELAY: reg_rdata <= {24'd0, sleep_delay};
        `POS_REG_RAMP_TIME: reg_rdata <= {16'd0, ramp_time};
        `POS_REG_TARGET: reg_rdata <= {18'd0, target_val};
        `POS_REG_FULL_SCALE: reg_rdata <= {16'd0, full_scale};
        `POS_REG_DECIMALS: reg_rdata <= {30'd0, decimals};
        `POS_REG_STATUS: reg_rdata <= {25'd0, out_reverse, sleep_active, stop_req, fault_out, alarm_out,
                                       fb_high_ind, fb_low_ind};
        `POS_REG_OUT_FREQ: reg_rdata <= {16'd0, out_freq};
        `POS_REG_TARGET_MON: reg_rdata <= {16'd0, target_display};
        `POS_REG_FB_MON: reg_rdata <= {16'd0, feedback_display};
        default: reg_rdata <= 32'd0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_LOW_NEEDS_HOLD: assert property (@(posedge ref_clk) disable iff (reset) // [R8]
    $rose(fb_low_ind) |-> $past(t_cond[0]) && $past(t_cnt[0]) > {1'b0, $past(low_time)})
    else $error("low indicator without a held low level");
  AST_TIMER_RESTART: assert property (@(posedge ref_clk) disable iff (reset) // [R22]
    !t_cond[0] |=> t_cnt[0] == 9'd0)
    else $error("low timer kept counting after the level dropped");
  AST_NEG_CLAMP: assert property (@(posedge ref_clk) disable iff (reset) // [R6]
    (mode inside {3'd1, 3'd2} && !rev_sel && pid_out < 18'sd0) |=> out_freq == 16'd0 && stop_req)
    else $error("negative output not clamped and stopped");
  AST_REVERSE_RUN: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
    $rose(out_reverse) |-> $past(rev_sel) && $past(mode) inside {3'd1, 3'd2})
    else $error("reverse run without reverse enabled");
  AST_ALARM_CAUSE: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    alarm_out |-> $past(act_base) == pos_pkg::POS_ACT_ALARM && (fb_low_ind || fb_high_ind))
    else $error("alarm without matching indicator");
  AST_FAULT_STOPS: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
    $rose(fault_out) |=> stop_req && out_freq == 16'd0)
    else $error("fault did not stop the motor");
  AST_SLEEP_STOPS: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
    $rose(sleep_active) |-> stop_req)
    else $error("sleep entered without a stop");
  AST_RAMP_BYPASS: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
    ramp_bypass ##1 ramp_bypass |-> target_ramped == $past(target_src))
    else $error("ramp not bypassed");
  AST_USER_LOCK: assert property (@(posedge ref_clk) disable iff (reset) // [R20]
    (reg_wr && reg_addr == `POS_REG_DECIMALS && unit_code != `POS_UNIT_USER) |=> $stable(decimals))
    else $error("decimals edited outside user units");
  AST_GAIN_RANGE: assert property (@(posedge ref_clk) disable iff (reset) // [R3]
    gain <= `POS_GAIN_MAX)
    else $error("gain outside 0.00 to 25.00");
  AST_DETECT_OFF: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (!det_en ##1 !det_en) |-> !fb_low_ind && !fb_high_ind)
    else $error("indicator with detection disabled");

endmodule

`default_nettype wire

/* File: testbench/pos_core_model.sv */
// Purpose: model of the pid core and command path
// Assumes: bench asks for levels, model launches them after an edge
// Notes: one edge of lag, as a registered core would give
`timescale 1ns/1ps
`default_nettype none
module pos_core_model (
  // clock
  input wire logic ref_clk,
  // wanted levels
  input wire logic [15:0] want_pid,
  input wire logic [15:0] want_cmd,
  input wire logic [15:0] want_fb,
  // to block
  output var logic signed [15:0] pid_in = 16'sh0,
  output var logic [15:0] freq_cmd = 16'h0,
  output var logic [15:0] feedback = 16'h0
);
  // registered so the block never sees a mid-cycle change
  always @(posedge ref_clk) begin
    pid_in <= want_pid;
    freq_cmd <= want_cmd;
    feedback <= want_fb;
  end
endmodule
`default_nettype wire

/* File: testbench/pos_pid_supervision_tb_top.sv */
// Purpose: self-checking bench of the pid output supervision block
// Assumes: tick of 4 cycles, stimulus by nba after the rising edge
// Notes: detection times kept tiny so each wait stays short
`include "pos_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module pos_pid_supervision_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd_val;
  logic signed [15:0] pid_in;
  logic [15:0] want_pid = 16'h0, want_cmd = 16'h0, want_fb = 16'h1388, freq_cmd, feedback, out_freq;
  logic out_reverse, stop_req, sleep_active, fb_low_ind, fb_high_ind, alarm_out, fault_out;
  logic [1:0] stop_method;
  int miscompares = 0;
  int total_checks = 0;
  // rows: mode, sign, reverse, pid, cmd, expected out, reverse, stop
  int tv[6][8] = '{'{1, 0, 1, -100, 0, 100, 1, 0}, '{1, 1, 1, 100, 0, 100, 1, 0},
    '{1, 0, 0, -100, 0, 0, 0, 1}, '{1, 0, 0, 200, 0, 200, 0, 0},
    '{3, 0, 1, -300, 1000, 700, 0, 0}, '{4, 0, 0, 500, 1000, 1500, 0, 0}};
  // ----------------------------------------
  // clock, partner and block
  // ----------------------------------------
  always #2 ref_clk = ~ref_clk;
  pos_core_model i_core (.ref_clk, .want_pid, .want_cmd, .want_fb, .pid_in, .freq_cmd, .feedback);
  pos_pid_supervision #(.TICK_CYCLES(4)) i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pid_in, .freq_cmd, .target_ext(16'h0fa0), .feedback,
    .max_freq_hz(16'h1770), .max_rpm(16'h0708), .out_freq, .out_reverse, .stop_req, .stop_method,
    .sleep_active, .fb_low_ind, .fb_high_ind, .alarm_out, .fault_out, .target_ramped(),
    .target_display(), .feedback_display());
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // pass n edges, then let their updates land before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic drive(input int p, input int c, input logic [15:0] f);
    @(posedge ref_clk);
    want_pid <= 16'(p);
    want_cmd <= 16'(c);
    want_fb <= f;
    settle(4);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return fb_low_ind;
      1: return fb_high_ind;
      2: return fault_out;
      3: return sleep_active;
      default: return alarm_out;
    endcase
  endfunction
  // bounded wait; running out is a mismatch and closes the run
  task automatic wait_sig(input int s, input logic v);
    for (int n = 0; n < 400 && pick(s) !== v; n++) settle(1);
    if (pick(s) !== v) begin
      miscompares++;
      $display("CHECK FAILED wait %0d expected %0h seen %0h", s, v, pick(s));
      end_sim();
    end
  endtask
  function automatic logic [31:0] ctl(input int m, a, u, s, r);
    return 32'((m << 2) | (a << 5) | (u << 9) | s | (r << 1));
  endfunction
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`POS_REG_GAIN);
    `CHK("gain", 32'h64, rd_val)
    rd(8'h40);
    `CHK("unmapped", 32'h0, rd_val)
    wr(`POS_REG_GAIN, 32'h9c5);
    rd(`POS_REG_GAIN);
    `CHK("gain", 32'h64, rd_val)
    foreach (tv[i]) begin
      wr(`POS_REG_CTRL, ctl(tv[i][0], 0, 1, tv[i][1], tv[i][2]));
      drive(tv[i][3], tv[i][4], 16'h1388);
      `CHK("out_freq", 16'(tv[i][5]), out_freq)
      `CHK("out_reverse", 1'(tv[i][6]), out_reverse)
      `CHK("stop_req", 1'(tv[i][7]), stop_req)
    end
    wr(`POS_REG_GAIN, 32'hc8);
    wr(`POS_REG_CTRL, ctl(1, 0, 1, 0, 1));
    drive(150, 0, 16'h1388);
    `CHK("out_freq", 16'h012c, out_freq)
    wr(`POS_REG_GAIN, 32'h64);
    // alarm action, then self clearing
    wr(`POS_REG_LOW_LEVEL, 32'h1f4);
    wr(`POS_REG_LOW_TIME, 32'h0);
    wr(`POS_REG_CTRL, ctl(1, 1, 1, 0, 0));
    drive(100, 0, 16'h0064);
    wait_sig(0, 1'b1);
    wait_sig(4, 1'b1);
    drive(100, 0, 16'h1388);
    `CHK("low ind", 1'b0, fb_low_ind)
    `CHK("alarm", 1'b0, alarm_out)
    // fault action stops the drive and latches
    wr(`POS_REG_CTRL, ctl(1, 2, 1, 0, 0));
    drive(100, 0, 16'h0064);
    wait_sig(2, 1'b1);
    settle(2);
    `CHK("stop_req", 1'b1, stop_req)
    `CHK("low ind", 1'b0, fb_low_ind)
    drive(100, 0, 16'h1388);
    `CHK("fault", 1'b1, fault_out)
    wr(`POS_REG_STATUS, 32'h8);
    wait_sig(2, 1'b0);
    // indicator only, pid disabled
    wr(`POS_REG_HIGH_LEVEL, 32'h1770);
    wr(`POS_REG_HIGH_TIME, 32'h1);
    wr(`POS_REG_CTRL, ctl(0, 3, 1, 0, 0));
    drive(0, 0, 16'h1b58);
    wait_sig(1, 1'b1);
    `CHK("alarm", 1'b0, alarm_out)
    drive(0, 0, 16'h1388);
    wr(`POS_REG_FULL_SCALE, 32'h1388);
    wr(`POS_REG_DECIMALS, 32'h1);
    rd(`POS_REG_FULL_SCALE);
    `CHK("full scale", 32'h0, rd_val)
    rd(`POS_REG_DECIMALS);
    `CHK("decimals", 32'h2, rd_val)
    wr(`POS_REG_CTRL, ctl(0, 0, 3, 0, 0));
    wr(`POS_REG_FULL_SCALE, 32'hea60);
    wr(`POS_REG_DECIMALS, 32'h3);
    rd(`POS_REG_FULL_SCALE);
    `CHK("full scale", 32'hea60, rd_val)
    rd(`POS_REG_DECIMALS);
    `CHK("decimals", 32'h3, rd_val)
    rd(`POS_REG_TARGET_MON);
    `CHK("target mon", 32'h5dc0, rd_val)
    rd(`POS_REG_FB_MON);
    `CHK("fb mon", 32'h7530, rd_val)
    // sleep on a low command, wake on a high one; stored target picked
    wr(`POS_REG_TARGET, 32'h2711);
    wr(`POS_REG_SLEEP_LEVEL, 32'h1f4);
    wr(`POS_REG_CTRL, ctl(0, 0, 1, 0, 0) | 32'h2100);
    drive(0, 100, 16'h1388);
    wait_sig(3, 1'b1);
    `CHK("stop_req", 1'b1, stop_req)
    `CHK("stop_method", 2'h2, stop_method)
    drive(0, 1000, 16'h1388);
    wait_sig(3, 1'b0);
    settle(2);
    `CHK("out_freq", 16'h03e8, out_freq)
    rd(`POS_REG_TARGET_MON);
    `CHK("target mon", 32'h0, rd_val)
    end_sim();
  end
endmodule
`default_nettype wire
